// ---- hdl/scopi_pkg.sv ----
// shared constants and types for the soft cpu output port interface
package scopi_pkg;
  localparam int SCOPI_DATA_W = 8;
  localparam int SCOPI_ADDR_W = 8;
  localparam int SCOPI_KADDR_W = 4;
  localparam int SCOPI_INSTR_CYCLES = 2;
  localparam logic [7:0] SCOPI_DATA_RST = 8'h00;
  localparam logic [7:0] SCOPI_ADDR_RST = 8'h00;
  localparam logic [7:0] SCOPI_GEN_PORT_DEF = 8'h20;
  localparam logic [3:0] SCOPI_K_PORT_DEF = 4'h8;
  localparam logic [3:0] SCOPI_KADDR_HI_FILL = 4'h0;

  typedef enum logic [3:0] {
    SCOPI_OP_OTHER = 4'b0001,
    SCOPI_OP_OUT_DIRECT = 4'b0010,
    SCOPI_OP_OUT_INDIRECT = 4'b0100,
    SCOPI_OP_OUT_CONST = 4'b1000
  } scopi_op_t;

  typedef enum logic [2:0] {
    SCOPI_ST_IDLE = 3'b001,
    SCOPI_ST_PRESENT = 3'b010,
    SCOPI_ST_STROBE = 3'b100
  } scopi_state_t;
endpackage : scopi_pkg

// ---- hdl/scopi_if.sv ----
// port bus between the processor output side and the user fabric
`timescale 1ns/1ns
interface scopi_if;
  import scopi_pkg::*;
  logic [SCOPI_DATA_W-1:0] out_data;
  logic [SCOPI_ADDR_W-1:0] port_address_bus;
  logic write_strobe;
  logic k_write_strobe;

  modport cpu (
    output out_data,
    output port_address_bus,
    output write_strobe,
    output k_write_strobe
  );

  modport fabric (
    input out_data,
    input port_address_bus,
    input write_strobe,
    input k_write_strobe
  );
endinterface : scopi_if

// ---- hdl/scopi_cpu_end.sv ----
// processor end: executes output instructions onto the port bus
`timescale 1ns/1ns
module scopi_cpu_end (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic INSTR_VALID,
  output logic INSTR_READY,
  input wire scopi_pkg::scopi_op_t INSTR_OP,
  input wire logic [7:0] IMMEDIATE_PORT_ADDRESS,
  input wire logic [7:0] IMMEDIATE_CONSTANT,
  input wire logic [7:0] SOURCE_REGISTER,
  input wire logic [7:0] ADDRESS_REGISTER,
  output logic BUSY,
  scopi_if.cpu PORT
);
  import scopi_pkg::*;

  scopi_state_t state_r;
  scopi_state_t state_nxt;
  scopi_op_t op_r;
  scopi_op_t op_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic wstb_r;
  logic wstb_nxt;
  logic kstb_r;
  logic kstb_nxt;
  logic take;
  logic gen_kind;
  logic k_kind;

  // a new instruction is taken no earlier than the end of the previous one's second cycle
  assign INSTR_READY = (state_r != SCOPI_ST_PRESENT);
  assign take = INSTR_VALID && INSTR_READY;

  // two states per instruction give the fixed two-cycle instruction time
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SCOPI_ST_IDLE: begin
        // the first offer may come on the first edge after reset
        if (take) begin
          state_nxt = SCOPI_ST_PRESENT;
        end
      end
      SCOPI_ST_PRESENT: begin
        // no offer is taken here, so two instructions never overlap
        state_nxt = SCOPI_ST_STROBE;
      end
      SCOPI_ST_STROBE: begin
        // a take in the strobe cycle starts the next instruction back to back
        if (take) begin
          state_nxt = SCOPI_ST_PRESENT;
        end else begin
          state_nxt = SCOPI_ST_IDLE;
        end
      end
      default: begin
        state_nxt = SCOPI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= SCOPI_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the kind of instruction under way decides which strobe, if any, follows
  always_comb begin
    op_nxt = op_r;
    if (take) begin
      op_nxt = INSTR_OP;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      op_r <= SCOPI_OP_OTHER;
    end else begin
      op_r <= op_nxt;
    end
  end

  // data stands from one take to the next, whatever the instruction
  always_comb begin
    data_nxt = data_r;
    if (take) begin
      unique case (INSTR_OP)
        SCOPI_OP_OUT_DIRECT: begin
          data_nxt = SOURCE_REGISTER;
        end
        SCOPI_OP_OUT_INDIRECT: begin
          data_nxt = SOURCE_REGISTER;
        end
        SCOPI_OP_OUT_CONST: begin
          data_nxt = IMMEDIATE_CONSTANT;
        end
        default: begin
          // other instructions leave their operand on the bus
          data_nxt = SOURCE_REGISTER;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      data_r <= SCOPI_DATA_RST;
    end else begin
      data_r <= data_nxt;
    end
  end

  // the address is held over both cycles so the fabric has two to decode it
  always_comb begin
    addr_nxt = addr_r;
    if (take) begin
      unique case (INSTR_OP)
        SCOPI_OP_OUT_DIRECT: begin
          addr_nxt = IMMEDIATE_PORT_ADDRESS;
        end
        SCOPI_OP_OUT_INDIRECT: begin
          // read at the take, so a later change of that register is not seen
          addr_nxt = ADDRESS_REGISTER;
        end
        SCOPI_OP_OUT_CONST: begin
          // upper nibble is undefined to the fabric; zero keeps it quiet
          addr_nxt = {SCOPI_KADDR_HI_FILL, IMMEDIATE_PORT_ADDRESS[3:0]};
        end
        default: begin
          addr_nxt = IMMEDIATE_PORT_ADDRESS;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      addr_r <= SCOPI_ADDR_RST;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // decoded once so both strobe groups read the same instruction kind
  assign gen_kind = (op_r == SCOPI_OP_OUT_DIRECT) || (op_r == SCOPI_OP_OUT_INDIRECT);
  assign k_kind = (op_r == SCOPI_OP_OUT_CONST);

  // strobe in the second cycle gives the fabric a full cycle of stable address
  always_comb begin
    wstb_nxt = 1'b0;
    if (state_r == SCOPI_ST_PRESENT) begin
      wstb_nxt = gen_kind;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wstb_r <= 1'b0;
    end else begin
      wstb_r <= wstb_nxt;
    end
  end

  // the two kinds are exclusive, so the two strobes can never meet
  always_comb begin
    kstb_nxt = 1'b0;
    if (state_r == SCOPI_ST_PRESENT) begin
      kstb_nxt = k_kind;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      kstb_r <= 1'b0;
    end else begin
      kstb_r <= kstb_nxt;
    end
  end

  // this end holds no register file or flags, so a constant output alters none
  assign BUSY = (state_r == SCOPI_ST_PRESENT);
  assign PORT.out_data = data_r;
  assign PORT.port_address_bus = addr_r;
  assign PORT.write_strobe = wstb_r;
  assign PORT.k_write_strobe = kstb_r;
endmodule : scopi_cpu_end

// ---- hdl/scopi_fabric_end.sv ----
// user fabric end: decodes the port bus into general, constant and hybrid ports
`timescale 1ns/1ns
module scopi_fabric_end #(
  parameter logic [7:0] GEN_PORT = scopi_pkg::SCOPI_GEN_PORT_DEF,
  parameter logic [3:0] K_PORT = scopi_pkg::SCOPI_K_PORT_DEF
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  scopi_if.fabric PORT,
  output logic [7:0] GEN_DATA,
  output logic GEN_WRITE,
  output logic [7:0] K_DATA,
  output logic K_WRITE,
  output logic [7:0] HYB_DATA,
  output logic HYB_WRITE
);
  import scopi_pkg::*;

  logic gen_hit_r;
  logic gen_hit_nxt;
  logic k_hit_r;
  logic k_hit_nxt;
  logic hyb_hit_r;
  logic hyb_hit_nxt;
  logic [7:0] gen_r;
  logic [7:0] gen_nxt;
  logic [7:0] k_r;
  logic [7:0] k_nxt;
  logic [7:0] hyb_r;
  logic [7:0] hyb_nxt;
  logic gen_wr_r;
  logic gen_wr_nxt;
  logic k_wr_r;
  logic k_wr_nxt;
  logic hyb_wr_r;
  logic hyb_wr_nxt;

  // address compare is pipelined over the first cycle to ease timing
  always_comb begin
    gen_hit_nxt = (PORT.port_address_bus == GEN_PORT);
    k_hit_nxt = (PORT.port_address_bus[3:0] == K_PORT);
    hyb_hit_nxt = (PORT.port_address_bus[3:0] == K_PORT);
  end

  always_comb begin
    gen_nxt = gen_r;
    k_nxt = k_r;
    hyb_nxt = hyb_r;
    gen_wr_nxt = PORT.write_strobe && gen_hit_r;
    k_wr_nxt = PORT.k_write_strobe && k_hit_r;
    // hybrid needs the full address for general writes but only the nibble for constants
    hyb_wr_nxt = (PORT.write_strobe && hyb_hit_r && (PORT.port_address_bus[7:4] == 4'h0))
      || (PORT.k_write_strobe && hyb_hit_r);
    if (gen_wr_nxt) begin
      gen_nxt = PORT.out_data;
    end
    if (k_wr_nxt) begin
      k_nxt = PORT.out_data;
    end
    if (hyb_wr_nxt) begin
      hyb_nxt = PORT.out_data;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      gen_hit_r <= 1'b0;
      k_hit_r <= 1'b0;
      hyb_hit_r <= 1'b0;
      gen_r <= SCOPI_DATA_RST;
      k_r <= SCOPI_DATA_RST;
      hyb_r <= SCOPI_DATA_RST;
      gen_wr_r <= 1'b0;
      k_wr_r <= 1'b0;
      hyb_wr_r <= 1'b0;
    end else begin
      gen_hit_r <= gen_hit_nxt;
      k_hit_r <= k_hit_nxt;
      hyb_hit_r <= hyb_hit_nxt;
      gen_r <= gen_nxt;
      k_r <= k_nxt;
      hyb_r <= hyb_nxt;
      gen_wr_r <= gen_wr_nxt;
      k_wr_r <= k_wr_nxt;
      hyb_wr_r <= hyb_wr_nxt;
    end
  end

  assign GEN_DATA = gen_r;
  assign GEN_WRITE = gen_wr_r;
  assign K_DATA = k_r;
  assign K_WRITE = k_wr_r;
  assign HYB_DATA = hyb_r;
  assign HYB_WRITE = hyb_wr_r;
endmodule : scopi_fabric_end

// ---- tb/scopi_chk.sv ----
// assertions on the port bus between the two ends
`timescale 1ns/1ns
module scopi_chk (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] out_data,
  input wire logic [7:0] port_address_bus,
  input wire logic write_strobe,
  input wire logic k_write_strobe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_strobe_excl: assert property (!(write_strobe && k_write_strobe))
    else $error("strobes overlap");
  a_gen_pulse: assert property (write_strobe |=> !write_strobe)
    else $error("general strobe too long");
  a_k_pulse: assert property (k_write_strobe |=> !k_write_strobe)
    else $error("constant strobe too long");
  a_write_gap: assert property ($rose(write_strobe) |-> !$past(k_write_strobe))
    else $error("writes too close");
  a_gen_bus_held: assert property (write_strobe |->
    $stable(out_data) && $stable(port_address_bus))
    else $error("bus moved under general strobe");
  a_k_bus_held: assert property (k_write_strobe |->
    $stable(out_data) && $stable(port_address_bus))
    else $error("bus moved under constant strobe");
  a_k_addr_hi: assert property (k_write_strobe |-> port_address_bus[7:4] == 4'h0)
    else $error("constant address high nibble set");
  // reset itself is the cause here, so this one is never disabled
  a_reset_quiet: assert property (disable iff (1'b0)
    SYS_RST |=> !write_strobe && !k_write_strobe)
    else $error("strobe after reset");
  c_gen: cover property (write_strobe);
  c_k: cover property (k_write_strobe);
  c_b2b: cover property (write_strobe ##2 k_write_strobe);
endmodule : scopi_chk

// ---- tb/testbench.sv ----
// self-checking bench joining the processor end and the fabric end
`timescale 1ns/1ns
module testbench;
  import scopi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, rdy, busy, gw, kw, hw;
  scopi_op_t op = SCOPI_OP_OTHER;
  logic [7:0] ia = 8'h00, ik = 8'h00, src = 8'h00, ar = 8'h00, gd, kd, hd, seen_a;
  int fail_count = 0, checks = 0, gn = 0, kn = 0, hn = 0, wn = 0;
  scopi_if bus_if ();
  scopi_cpu_end i_scopi_cpu_end (.CLK(clk), .SYS_RST(rst), .INSTR_VALID(vld), .INSTR_READY(rdy),
    .INSTR_OP(op), .IMMEDIATE_PORT_ADDRESS(ia), .IMMEDIATE_CONSTANT(ik), .SOURCE_REGISTER(src),
    .ADDRESS_REGISTER(ar), .BUSY(busy), .PORT(bus_if.cpu));
  scopi_fabric_end i_scopi_fabric_end (.CLK(clk), .SYS_RST(rst), .PORT(bus_if.fabric),
    .GEN_DATA(gd), .GEN_WRITE(gw), .K_DATA(kd), .K_WRITE(kw), .HYB_DATA(hd), .HYB_WRITE(hw));
  scopi_chk i_scopi_chk (.CLK(clk), .SYS_RST(rst), .out_data(bus_if.out_data),
    .port_address_bus(bus_if.port_address_bus), .write_strobe(bus_if.write_strobe),
    .k_write_strobe(bus_if.k_write_strobe));
  // pulse counters expose a stuck write as an extra count
  always @(posedge clk) begin
    if (gw === 1'b1) gn++;
    if (kw === 1'b1) kn++;
    if (hw === 1'b1) hn++;
    if (bus_if.write_strobe === 1'b1) wn++;
    if (bus_if.write_strobe === 1'b1 || bus_if.k_write_strobe === 1'b1)
      seen_a = bus_if.port_address_bus;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    $display("checks=%0d fails=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // valid stays high across calls, so back-to-back offers wait out the refused cycle
  task issue(input scopi_op_t o, input logic [7:0] a, k, s, r);
    int n;
    n = 0;
    vld = 1'b1;
    op = o;
    ia = a;
    ik = k;
    src = s;
    ar = r;
    while (rdy !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rdy !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    @(posedge clk);
    #1;
  endtask : issue
  task drain;
    vld = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : drain
  task t_direct;
    issue(SCOPI_OP_OUT_DIRECT, 8'h20, 8'hC3, 8'h55, 8'h21);
    check({7'h00, busy}, 8'h01);
    check({7'h00, rdy}, 8'h00);
    drain();
    check({7'h00, busy}, 8'h00);
    check(gd, 8'h55);
    check(gn[7:0], 8'h01);
    check(seen_a, 8'h20);
    $display("direct done");
  endtask : t_direct
  task t_b2b;
    issue(SCOPI_OP_OUT_INDIRECT, 8'h11, 8'h00, 8'hA5, 8'h20);
    issue(SCOPI_OP_OUT_CONST, 8'hF8, 8'h3C, 8'h00, 8'h00);
    drain();
    check(gd, 8'hA5);
    check(kd, 8'h3C);
    check(seen_a, 8'h08);
    check(hd, 8'h3C);
    issue(SCOPI_OP_OUT_DIRECT, 8'h08, 8'h00, 8'h77, 8'h00);
    drain();
    check(hd, 8'h77);
    check({gn[3:0], kn[1:0], hn[1:0]}, 8'h26);
    $display("back to back done");
  endtask : t_b2b
  task t_other;
    issue(SCOPI_OP_OTHER, 8'h20, 8'h20, 8'h99, 8'h20);
    issue(SCOPI_OP_OUT_DIRECT, 8'h21, 8'h00, 8'h66, 8'h00);
    drain();
    check(wn[7:0], 8'h04);
    check(gd, 8'hA5);
    check(seen_a, 8'h21);
    $display("other done");
  endtask : t_other
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_direct();
    t_b2b();
    t_other();
    print_verdict();
  end
endmodule : testbench
